// >>> logic/tmr_pkg.sv
/*
 * Shared constants and types of the dual timer control and status block.
 * Assumes an APB master with 32-bit data and 8-bit timer counters outside.
 */
package tmr_pkg;
    // Bus shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 8;
    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_Y_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_X_CTRL = 8'h04;
    // Field positions in each control and status register
    localparam int REG_MSB = 7;
    localparam int FLAG_LSB = 4;
    localparam int OS_MSB = 3;
    localparam int OSB_LSB = 2;
    localparam int OSA_MSB = 1;
    // Positions inside the four-bit flag group
    localparam int F_MATCH_B = 3;
    localparam int F_MATCH_A = 2;
    localparam int F_OVF = 1;
    localparam int F_BIT4 = 0;
    // Flag bits that only a read-then-write can clear
    localparam logic [3:0] ARM_MASK_PLAIN = 4'hE;
    localparam logic [3:0] ARM_MASK_CAP = 4'hF;
    // Reset values
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic PIN_RST = 1'b0;
    // Counter wrap points
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    // Output select codes
    localparam logic [1:0] OS_KEEP = 2'h0;
    localparam logic [1:0] OS_LOW = 2'h1;
    localparam logic [1:0] OS_HIGH = 2'h2;
    localparam logic [1:0] OS_TOGGLE = 2'h3;

    typedef enum logic {CAP_IDLE, CAP_HIGH} tmr_cap_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } tmr_apb_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } tmr_apb_rsp_s;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] cmp_a;
        logic [CNT_W-1:0] cmp_b;
    } tmr_cnt_s;

    typedef struct packed {
        logic [3:0] flag;
        logic [3:0] os;
        logic pin;
        logic [3:0] armed;
        logic eq_a;
        logic eq_b;
        logic [CNT_W-1:0] cnt_prev;
        logic primed;
    } tmr_chan_state_s;

    typedef struct packed {
        tmr_apb_rsp_s rsp;
        logic irq;
        tmr_cap_e cap;
        logic ext_prev;
    } tmr_top_state_s;

    localparam tmr_chan_state_s CHAN_RST = '{flag: REG_RST[REG_MSB:FLAG_LSB],
        os: REG_RST[OS_MSB:0], pin: PIN_RST, default: '0};
endpackage

// >>> logic/tmr_chan.sv
/*
 * One timer channel: match and overflow flags, bit 4, output selects, pin.
 * Assumes a synchronous reset copy and one-cycle register strobes from the top.
 */
`timescale 1ns/1ps
module tmr_chan #(
    parameter bit CAPTURE = 1'b0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_en,
    // Counter and events
    input wire tmr_pkg::tmr_cnt_s i_cnt,
    input wire logic i_cap_evt,
    // Register access
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_rd_data,
    input wire logic [7:0] i_wdata,
    // Outputs
    output logic [7:0] o_reg,
    output logic o_pin
);
    import tmr_pkg::*;

    tmr_chan_state_s s_reg;
    tmr_chan_state_s s_next;
    logic eq_a;
    logic eq_b;
    logic match_a;
    logic match_b;
    logic ovf_evt;
    logic [3:0] arm_mask;

    function automatic logic pin_apply(input logic pin, input logic [1:0] sel);
        logic r;
        r = pin;
        unique case (sel)
            OS_KEEP: r = pin;
            OS_LOW: r = 1'b0;
            OS_HIGH: r = 1'b1;
            OS_TOGGLE: r = !pin;
        endcase
        return r;
    endfunction

    // Matches act once on the cycle equality begins
    assign eq_a = i_cnt.cnt == i_cnt.cmp_a;
    assign eq_b = i_cnt.cnt == i_cnt.cmp_b;
    assign match_a = eq_a && !s_reg.eq_a;
    assign match_b = eq_b && !s_reg.eq_b;
    assign ovf_evt = s_reg.primed && s_reg.cnt_prev == CNT_MAX && i_cnt.cnt == CNT_ZERO;
    assign arm_mask = CAPTURE ? ARM_MASK_CAP : ARM_MASK_PLAIN;

    always_comb begin
        s_next = s_reg;
        if (i_en) begin
            s_next.eq_a = eq_a;
            s_next.eq_b = eq_b;
            s_next.cnt_prev = i_cnt.cnt;
            s_next.primed = 1'b1;
            if (i_rd) begin
                s_next.armed = s_reg.armed | (i_rd_data[REG_MSB:FLAG_LSB] & arm_mask);
            end
            if (i_wr) begin
                // Zero clears an armed flag, one is ignored
                s_next.flag = s_reg.flag & ~(~i_wdata[REG_MSB:FLAG_LSB] & s_reg.armed & arm_mask);
                if (!CAPTURE) begin
                    s_next.flag[F_BIT4] = i_wdata[FLAG_LSB];
                end
                s_next.os = i_wdata[OS_MSB:0];
                s_next.armed = 4'h0;
            end
            // Events override a clear in the same cycle
            s_next.flag[F_MATCH_B] = s_next.flag[F_MATCH_B] | match_b;
            s_next.flag[F_MATCH_A] = s_next.flag[F_MATCH_A] | match_a;
            s_next.flag[F_OVF] = s_next.flag[F_OVF] | ovf_evt;
            s_next.flag[F_BIT4] = s_next.flag[F_BIT4] | (CAPTURE & i_cap_evt);
            // B acts after A, so B wins on a shared cycle
            if (match_a) begin
                s_next.pin = pin_apply(s_next.pin, s_reg.os[OSA_MSB:0]);
            end
            if (match_b) begin
                s_next.pin = pin_apply(s_next.pin, s_reg.os[OS_MSB:OSB_LSB]);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_reg <= CHAN_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_reg = {s_reg.flag, s_reg.os};
    assign o_pin = s_reg.pin;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    match_b_set_a: assert property (i_en && match_b |=> s_reg.flag[F_MATCH_B])
        else $error("match B flag not set");
    match_a_set_a: assert property (i_en && match_a |=> s_reg.flag[F_MATCH_A])
        else $error("match A flag not set");
    ovf_set_a: assert property (i_en && ovf_evt |=> s_reg.flag[F_OVF])
        else $error("overflow flag not set");
    clear_armed_a: assert property ($fell(s_reg.flag[F_MATCH_B]) |->
        $past(i_wr && !i_wdata[REG_MSB] && s_reg.armed[F_MATCH_B]))
        else $error("flag cleared without read then write");
    one_ignored_a: assert property (i_en && i_wr && i_wdata[FLAG_LSB+F_OVF]
        && !s_reg.flag[F_OVF] && !ovf_evt |=> !s_reg.flag[F_OVF])
        else $error("write of one set a flag");
    set_wins_a: assert property (i_en && i_wr && match_a |=> s_reg.flag[F_MATCH_A])
        else $error("event lost against clear");
    pin_b_low_a: assert property (i_en && match_b && s_reg.os[OS_MSB:OSB_LSB] == OS_LOW
        |=> !o_pin)
        else $error("match B did not drive low");
    pin_a_high_a: assert property (i_en && match_a && !match_b
        && s_reg.os[OSA_MSB:0] == OS_HIGH |=> o_pin)
        else $error("match A did not drive high");
endmodule

// >>> logic/tmr_top.sv
/*
 * Dual timer control and status registers behind an APB slave.
 * Assumes counters and compare constants arrive from outside, synchronous
 * to i_core_clk, as does the external reset signal used for capture.
 */
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - Channel Y match B flag sets when counter Y equals constant B.
// - Channel Y match A flag sets when counter Y equals constant A.
// - Channel Y overflow flag sets when counter Y wraps from FF to 00.
// - A flag clears only after it was read as one, then written zero.
// - Writing one to any flag bit has no effect.
// - Channel Y bit 4 gates the capture interrupt request.
// - Match B updates pin Y per bits 3:2: keep, low, high, toggle.
// - Match A updates pin Y per bits 1:0: keep, low, high, toggle.
// - Channel X match B flag sets when counter X equals constant B.
// - Channel X match A flag sets when counter X equals constant A.
// - Channel X overflow flag sets when counter X wraps from FF to 00.
// - Capture flag sets after a rise then a fall of the external reset.
// - Capture flag clears only after read as one, then written zero.
// - Match B updates pin X per bits 3:2: keep, low, high, toggle.
// - Match A updates pin X per bits 1:0: keep, low, high, toggle.
module tmr_top (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_clk_en,
    // APB slave
    input wire tmr_pkg::tmr_apb_req_s i_apb,
    output tmr_pkg::tmr_apb_rsp_s o_apb,
    // Timer channel Y
    input wire tmr_pkg::tmr_cnt_s i_tmr_y,
    // Timer channel X
    input wire tmr_pkg::tmr_cnt_s i_tmr_x,
    input wire logic i_ext_reset,
    // Pins and request
    output logic o_timer_out_pin_y,
    output logic o_timer_out_pin_x,
    output logic o_capture_irq_request
);
    import tmr_pkg::*;

    logic [1:0] rst_sync_reg;
    logic rst_n;
    tmr_top_state_s s_reg;
    tmr_top_state_s s_next;
    logic sel_y;
    logic sel_x;
    logic mapped;
    logic setup;
    logic done;
    logic wr_y;
    logic wr_x;
    logic rd_y;
    logic rd_x;
    logic cap_evt;
    logic [7:0] y_reg;
    logic [7:0] x_reg;
    logic [7:0] rd_image;

    // Reset release through two flip-flops
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Address decode
    assign sel_y = i_apb.paddr == ADDR_Y_CTRL;
    assign sel_x = i_apb.paddr == ADDR_X_CTRL;
    assign mapped = sel_y || sel_x;

    // Answer prepared while selected and not yet ready
    assign setup = i_clk_en && i_apb.psel && !s_reg.rsp.pready;
    // Access completes on the edge that sees pready
    assign done = i_clk_en && i_apb.psel && i_apb.penable && s_reg.rsp.pready;

    assign wr_y = done && i_apb.pwrite && sel_y;
    assign wr_x = done && i_apb.pwrite && sel_x;
    assign rd_y = done && !i_apb.pwrite && sel_y;
    assign rd_x = done && !i_apb.pwrite && sel_x;

    always_comb begin
        rd_image = 8'h00;
        if (sel_y) begin
            rd_image = y_reg;
        end else if (sel_x) begin
            rd_image = x_reg;
        end
    end

    // Rise then fall of the external reset signal
    assign cap_evt = i_clk_en && s_reg.cap == CAP_HIGH
        && s_reg.ext_prev && !i_ext_reset;

    always_comb begin
        s_next = s_reg;
        if (i_clk_en) begin
            s_next.ext_prev = i_ext_reset;
            unique case (s_reg.cap)
                CAP_IDLE: begin
                    if (i_ext_reset && !s_reg.ext_prev) begin
                        s_next.cap = CAP_HIGH;
                    end
                end
                CAP_HIGH: begin
                    if (cap_evt) begin
                        s_next.cap = CAP_IDLE;
                    end
                end
            endcase
            // Request follows flag and enable one cycle later
            s_next.irq = y_reg[FLAG_LSB] && x_reg[FLAG_LSB];
            if (setup) begin
                s_next.rsp.pready = 1'b1;
                s_next.rsp.pslverr = !mapped;
                s_next.rsp.prdata = {{(DATA_W-8){1'b0}}, rd_image};
            end
            if (done) begin
                s_next.rsp.pready = 1'b0;
                s_next.rsp.pslverr = 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{rsp: '0, irq: 1'b0, cap: CAP_IDLE, ext_prev: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    tmr_chan #(
        .CAPTURE(1'b0)
    ) u_chan_y (
        .i_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_en(i_clk_en),
        .i_cnt(i_tmr_y),
        .i_cap_evt(1'b0),
        .i_wr(wr_y),
        .i_rd(rd_y),
        .i_rd_data(s_reg.rsp.prdata[7:0]),
        .i_wdata(i_apb.pwdata[7:0]),
        .o_reg(y_reg),
        .o_pin(o_timer_out_pin_y)
    );

    tmr_chan #(
        .CAPTURE(1'b1)
    ) u_chan_x (
        .i_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_en(i_clk_en),
        .i_cnt(i_tmr_x),
        .i_cap_evt(cap_evt),
        .i_wr(wr_x),
        .i_rd(rd_x),
        .i_rd_data(s_reg.rsp.prdata[7:0]),
        .i_wdata(i_apb.pwdata[7:0]),
        .o_reg(x_reg),
        .o_pin(o_timer_out_pin_x)
    );

    assign o_apb = s_reg.rsp;
    assign o_capture_irq_request = s_reg.irq;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!rst_n);

    sequence cap_armed_s;
        s_reg.cap == CAP_HIGH && i_clk_en;
    endsequence

    sequence cap_fall_s;
        s_reg.ext_prev && !i_ext_reset;
    endsequence

    sequence read_one_s(logic [7:0] img);
        rd_x && s_reg.rsp.prdata[FLAG_LSB] ##1 img[FLAG_LSB];
    endsequence

    capture_flag_a: assert property (cap_armed_s and cap_fall_s |=> x_reg[FLAG_LSB])
        else $error("capture flag not set after rise and fall");
    capture_cause_a: assert property ($rose(x_reg[FLAG_LSB]) |-> $past(cap_evt))
        else $error("capture flag set without edges");
    capture_hold_a: assert property (read_one_s(x_reg) ##1 !done[*2]
        |-> x_reg[FLAG_LSB])
        else $error("capture flag cleared without a write");
    irq_gate_a: assert property (i_clk_en |=>
        o_capture_irq_request == $past(y_reg[FLAG_LSB] && x_reg[FLAG_LSB]))
        else $error("capture request does not follow gate");
    irq_masked_a: assert property (!y_reg[FLAG_LSB] && i_clk_en |=>
        !o_capture_irq_request)
        else $error("capture request not suppressed");
    write_one_a: assert property (wr_y && i_apb.pwdata[REG_MSB]
        && !y_reg[REG_MSB] |=> !$rose(y_reg[REG_MSB]) || $past(i_tmr_y.cnt == i_tmr_y.cmp_b))
        else $error("write of one set a flag");
    ready_pulse_a: assert property (done |=> !o_apb.pready)
        else $error("pready held past the access");
    ready_setup_a: assert property (setup |=> o_apb.pready && o_apb.pslverr == $past(!mapped))
        else $error("no answer after setup");

    // Read image captured at setup and held for the access
    sequence setup_y_s;
        setup && sel_y;
    endsequence

    sequence setup_x_s;
        setup && sel_x;
    endsequence

    rdata_y_a: assert property (setup_y_s |=> o_apb.prdata[7:0] == $past(y_reg)
        && o_apb.prdata[DATA_W-1:8] == '0)
        else $error("read image of channel Y wrong");
    rdata_x_a: assert property (setup_x_s |=> o_apb.prdata[7:0] == $past(x_reg)
        && o_apb.prdata[DATA_W-1:8] == '0)
        else $error("read image of channel X wrong");
    unmapped_err_a: assert property (setup && !mapped |=> o_apb.pslverr
        && o_apb.prdata == '0)
        else $error("unmapped access not refused");
    unmapped_quiet_a: assert property (done && !mapped |=>
        y_reg[OS_MSB:0] == $past(y_reg[OS_MSB:0]) && x_reg[OS_MSB:0] == $past(x_reg[OS_MSB:0]))
        else $error("unmapped write changed a register");
    os_written_a: assert property (wr_y |=> y_reg[OS_MSB:0] == $past(i_apb.pwdata[OS_MSB:0]))
        else $error("output select of channel Y not written");
    ready_idle_a: assert property (!i_apb.psel && !o_apb.pready |=> !o_apb.pready)
        else $error("pready raised without select");
    freeze_rsp_a: assert property (!i_clk_en |=> o_apb == $past(o_apb))
        else $error("bus answer moved while frozen");
    freeze_out_a: assert property (!i_clk_en |=> $stable(o_timer_out_pin_y)
        && $stable(o_timer_out_pin_x) && $stable(o_capture_irq_request))
        else $error("outputs moved while frozen");
    cap_rise_a: assert property (i_clk_en && s_reg.cap == CAP_IDLE && i_ext_reset
        && !s_reg.ext_prev |=> s_reg.cap == CAP_HIGH)
        else $error("rise of external reset missed");
    irq_needs_flag_a: assert property (o_capture_irq_request |-> $past(x_reg[FLAG_LSB]))
        else $error("capture request without flag");
    cap_clear_a: assert property ($fell(x_reg[FLAG_LSB]) |->
        $past(wr_x && !i_apb.pwdata[FLAG_LSB]))
        else $error("capture flag cleared without a write");
endmodule

// >>> sim/tb.sv
/*
 * Self-checking bench for the dual timer control and status block.
 * Assumes tmr_top with an APB slave at 0x00/0x04; assertions live in the design.
 */
`timescale 1ns/1ps
module tb;
    import tmr_pkg::*;

    localparam logic [7:0] IDLE = 8'h08;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic ext_rst = 1'b0;
    tmr_apb_req_s req = '0;
    tmr_apb_rsp_s rsp;
    tmr_cnt_s tc[2];
    logic pin_y;
    logic pin_x;
    logic irq;
    logic [32:0] exp_q[$];
    logic [7:0] m[2];
    logic [3:0] arm[2];
    logic pin[2];
    int n_mismatch = 0;
    int samples_checked = 0;
    int seed = 32'h67DE;
    int seq[5] = '{2, 0, 1, 3, 3};

    always #5 clk = ~clk;

    tmr_top u_dut (
        .i_core_clk(clk),
        .i_arst_n(rst_n),
        .i_clk_en(clk_en),
        .i_apb(req),
        .o_apb(rsp),
        .i_tmr_y(tc[0]),
        .i_tmr_x(tc[1]),
        .i_ext_reset(ext_rst),
        .o_timer_out_pin_y(pin_y),
        .o_timer_out_pin_x(pin_x),
        .o_capture_irq_request(irq)
    );

    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        if (exp_q.size() != 0) n_mismatch++;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Read results leave the queue in issue order
    always @(posedge clk) begin
        if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite) begin
            if (exp_q.size() == 0) n_mismatch++;
            else check("prdata", {rsp.pslverr, rsp.prdata}, exp_q.pop_front());
        end
    end

    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= {24'($random(seed)), d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic rd(input int ch);
        exp_q.push_back({25'h0, m[ch]});
        xfer(8'(ch * 4), 1'b0, 8'h00);
        arm[ch] = m[ch][7:4] & (ch ? ARM_MASK_CAP : ARM_MASK_PLAIN);
    endtask

    task automatic wr(input int ch, input logic [7:0] d);
        logic [3:0] fm;
        fm = ch ? ARM_MASK_CAP : ARM_MASK_PLAIN;
        xfer(8'(ch * 4), 1'b1, d);
        m[ch][7:4] = m[ch][7:4] & ~(arm[ch] & ~d[7:4] & fm);
        if (ch == 0) m[0][4] = d[4];
        m[ch][3:0] = d[3:0];
        arm[ch] = 4'h0;
    endtask

    // Event k: 0 match A, 1 match B, 2 overflow
    task automatic hit(input int ch, input int k);
        logic [1:0] c;
        @(posedge clk);
        if (k == 2) tc[ch].cnt <= CNT_MAX;
        else tc[ch].cnt <= k ? tc[ch].cmp_b : tc[ch].cmp_a;
        @(posedge clk);
        tc[ch].cnt <= (k == 2) ? CNT_ZERO : IDLE;
        @(posedge clk);
        tc[ch].cnt <= IDLE;
        repeat (2) @(posedge clk);
        m[ch][(k == 2) ? 5 : 6 + k] = 1'b1;
        c = k ? m[ch][3:2] : m[ch][1:0];
        if (k < 2 && c == OS_LOW) pin[ch] = 1'b0;
        if (k < 2 && c == OS_HIGH) pin[ch] = 1'b1;
        if (k < 2 && c == OS_TOGGLE) pin[ch] = ~pin[ch];
        check("pin", {32'h0, ch ? pin_x : pin_y}, {32'h0, pin[ch]});
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        results();
    end

    initial begin
        logic [31:0] r;
        for (int ch = 0; ch < 2; ch++) begin
            r = $random(seed);
            tc[ch].cmp_a = 8'h10 + {2'h0, r[5:0]};
            tc[ch].cmp_b = tc[ch].cmp_a + 8'h40;
            tc[ch].cnt = IDLE;
            m[ch] = REG_RST;
            arm[ch] = 4'h0;
            pin[ch] = PIN_RST;
        end
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(0);
        rd(1);
        exp_q.push_back({1'b1, 32'h0});
        xfer(8'h08, 1'b0, 8'h00);
        xfer(8'h0C, 1'b1, 8'hFF);
        for (int ch = 0; ch < 2; ch++) begin
            wr(ch, 8'hFF);
            rd(ch);
            for (int k = 0; k < 2; k++)
                for (int i = 0; i < 5; i++) begin
                    wr(ch, 8'hE0 | 8'(k ? seq[i] << 2 : seq[i]));
                    hit(ch, k);
                end
            hit(ch, 2);
            wr(ch, 8'h00);
            rd(ch);
            wr(ch, 8'h00);
            rd(ch);
        end
        wr(0, 8'h10);
        @(posedge clk);
        ext_rst <= 1'b1;
        repeat (3) @(posedge clk);
        ext_rst <= 1'b0;
        repeat (3) @(posedge clk);
        m[1][4] = 1'b1;
        check("irq", {32'h0, irq}, {32'h0, 1'b1});
        wr(0, 8'h00);
        repeat (3) @(posedge clk);
        check("irq", {32'h0, irq}, {32'h0, 1'b0});
        wr(1, 8'h00);
        rd(1);
        wr(1, 8'h00);
        rd(1);
        // Match while frozen must leave no trace
        @(posedge clk);
        clk_en <= 1'b0;
        tc[0].cnt <= tc[0].cmp_a;
        @(posedge clk);
        tc[0].cnt <= IDLE;
        @(posedge clk);
        clk_en <= 1'b1;
        rd(0);
        check("pin", {32'h0, pin_y}, {32'h0, pin[0]});
        repeat (3) @(posedge clk);
        results();
    end
endmodule
